// file: hdl/ldc_top.sv
// led dimming controller top: apb register file, mode decode and drive outputs
`timescale 1ns/1ps
module ldc_top #(
  parameter int RAMP_STEP0 = ldc_pkg::RAMP_STEP0_CYC,
  parameter int RAMP_STEP1 = ldc_pkg::RAMP_STEP1_CYC,
  parameter int RAMP_STEP2 = ldc_pkg::RAMP_STEP2_CYC,
  parameter int RAMP_STEP3 = ldc_pkg::RAMP_STEP3_CYC,
  parameter int PWM_BASE_DIV = ldc_pkg::PWM_BASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pdn_clear,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ldc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [ldc_pkg::CODE_W-1:0] o_sink_code,
  output logic [ldc_pkg::CUR_W-1:0] o_sink_current,
  output logic o_sink_en,
  output logic o_boost_en,
  output logic o_standby_en,
  output logic o_feedback_mode
);
  import ldc_pkg::*;

  typedef struct packed {
    logic enable;
    logic [1:0] ramp_speed;
    logic drive_mode_sel_a;
    logic drive_mode_sel_b;
    logic [1:0] dim_clock_sel;
    logic [CODE_W-1:0] code;
    logic [3:0] dim_numerator;
    logic [3:0] dim_denominator;
    logic [31:0] rdata;
    logic [CODE_W-1:0] sink_code;
    logic [CUR_W-1:0] sink_current;
    logic sink_en;
    logic boost_en;
    logic standby_en;
    logic feedback;
  } ldc_top_s;

  ldc_top_s s_r;
  ldc_top_s s_nxt;

  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic wr_take;
  ldc_mode_e mode;
  logic ramp_enable;
  logic [CODE_W-1:0] ramp_level;
  logic ramp_on;
  logic pwm_run;
  logic pwm_on;
  logic [CODE_W-1:0] goal;
  logic ramping;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_CTRL: addr_mapped = 1'b1;
      OFS_DAC: addr_mapped = 1'b1;
      OFS_PWM: addr_mapped = 1'b1;
      OFS_STAT: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // fixed boost and reserved modes never use the ramped sink
  function automatic logic sink_mode(input ldc_mode_e m);
    sink_mode = (m == LDC_MODE_CC) || (m == LDC_MODE_PWM);
  endfunction : sink_mode

  // register images: unused bits always read back as zero
  function automatic logic [31:0] ctrl_image(input ldc_top_s s);
    logic [31:0] w;
    w = REG_RST;
    w[CTRL_EN_BIT] = s.enable;
    w[CTRL_SPD_LSB +: 2] = s.ramp_speed;
    w[CTRL_SELA_BIT] = s.drive_mode_sel_a;
    w[CTRL_SELB_BIT] = s.drive_mode_sel_b;
    w[CTRL_CLK_LSB +: 2] = s.dim_clock_sel;
    ctrl_image = w;
  endfunction : ctrl_image

  function automatic logic [31:0] dac_image(input logic [CODE_W-1:0] code);
    logic [31:0] w;
    w = REG_RST;
    w[DAC_CODE_LSB +: CODE_W] = code;
    dac_image = w;
  endfunction : dac_image

  function automatic logic [31:0] ratio_image(input logic [3:0] num, input logic [3:0] den);
    logic [31:0] w;
    w = REG_RST;
    w[PWM_NUM_LSB +: 4] = num;
    w[PWM_DEN_LSB +: 4] = den;
    ratio_image = w;
  endfunction : ratio_image

  function automatic logic [31:0] status_image(input logic [CODE_W-1:0] level, input logic on,
                                               input logic phase, input ldc_mode_e m, input logic moving);
    logic [31:0] w;
    w = REG_RST;
    w[STAT_LEVEL_LSB +: CODE_W] = level;
    w[STAT_ON_BIT] = on;
    w[STAT_PHASE_BIT] = phase;
    w[STAT_MODE_LSB +: 2] = m;
    w[STAT_RAMP_BIT] = moving;
    status_image = w;
  endfunction : status_image

  // writes touch only their own fields, so the rest of the state passes through
  function automatic ldc_top_s ctrl_apply(input ldc_top_s s, input logic [31:0] w);
    ldc_top_s t;
    t = s;
    t.enable = w[CTRL_EN_BIT];
    t.ramp_speed = w[CTRL_SPD_LSB +: 2];
    t.drive_mode_sel_a = w[CTRL_SELA_BIT];
    t.drive_mode_sel_b = w[CTRL_SELB_BIT];
    t.dim_clock_sel = w[CTRL_CLK_LSB +: 2];
    ctrl_apply = t;
  endfunction : ctrl_apply

  function automatic ldc_top_s ratio_apply(input ldc_top_s s, input logic [31:0] w);
    ldc_top_s t;
    t = s;
    t.dim_numerator = w[PWM_NUM_LSB +: 4];
    t.dim_denominator = w[PWM_DEN_LSB +: 4];
    ratio_apply = t;
  endfunction : ratio_apply

  // drive levels of one mode, packed as sink, boost, standby, feedback
  function automatic logic [3:0] drive_levels(input ldc_mode_e m, input logic en, input logic on,
                                              input logic pulse);
    logic [3:0] d;
    d = 4'h0;
    case (m)
      LDC_MODE_CC: begin
        d[3] = on;
        d[2] = on;
      end
      LDC_MODE_PWM: begin
        d[3] = on && pulse;
        d[2] = on && pulse;
        // keeps the pin from swinging fully between pulses
        d[1] = en || on;
      end
      LDC_MODE_FIXED: begin
        // boost regulates on the pin; the current sink stays idle
        d[2] = en;
        d[0] = 1'b1;
      end
      LDC_MODE_RSVD: begin
        d = 4'h0;
      end
      default: begin
        d = 4'h0;
      end
    endcase
    drive_levels = d;
  endfunction : drive_levels

  assign mode = ldc_decode_mode(s_r.drive_mode_sel_a, s_r.drive_mode_sel_b);

  assign ramp_enable = s_r.enable && sink_mode(mode);
  // goal the ramp is heading for; status reports a gap as ramping only while the ramp is on
  assign goal = ramp_enable ? s_r.code : '0;
  assign ramping = ramp_on && (ramp_level != goal);
  // the waveform runs while the sink is lit in dimming mode
  assign pwm_run = (mode == LDC_MODE_PWM) && ramp_on;

  ldc_ramp #(
    .STEP0(RAMP_STEP0),
    .STEP1(RAMP_STEP1),
    .STEP2(RAMP_STEP2),
    .STEP3(RAMP_STEP3)
  ) u_ramp (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(i_pdn_clear),
    .i_enable(ramp_enable),
    .i_speed(s_r.ramp_speed),
    .i_target(s_r.code),
    .o_level(ramp_level),
    .o_on(ramp_on)
  );

  ldc_pwm #(
    .BASE_DIV(PWM_BASE_DIV)
  ) u_pwm (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_run(pwm_run),
    .i_clk_sel(s_r.dim_clock_sel),
    .i_num(s_r.dim_numerator),
    .i_den(s_r.dim_denominator),
    .o_on(pwm_on),
    .o_tick()
  );

  // zero wait state slave; unmapped addresses answer with an error
  assign setup_ph = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign mapped = addr_mapped(i_paddr);
  assign wr_take = access_ph && i_pwrite && mapped && i_pstrb[0];
  assign o_pready = access_ph;
  assign o_pslverr = access_ph && !mapped;

  always_comb begin
    s_nxt = s_r;

    // read data sampled at setup so it comes from a flop in the access cycle
    if (setup_ph && !i_pwrite) begin
      s_nxt.rdata = REG_RST;
      case (i_paddr)
        OFS_CTRL: begin
          s_nxt.rdata = ctrl_image(s_r);
        end
        OFS_DAC: begin
          s_nxt.rdata = dac_image(s_r.code);
        end
        OFS_PWM: begin
          s_nxt.rdata = ratio_image(s_r.dim_numerator, s_r.dim_denominator);
        end
        OFS_STAT: begin
          s_nxt.rdata = status_image(ramp_level, ramp_on, pwm_on, mode, ramping);
        end
        default: begin
          s_nxt.rdata = REG_RST;
        end
      endcase
    end

    // status word is read only; writes to it are dropped silently
    if (wr_take) begin
      case (i_paddr)
        OFS_CTRL: begin
          s_nxt = ctrl_apply(s_nxt, i_pwdata);
        end
        OFS_DAC: begin
          s_nxt.code = i_pwdata[DAC_CODE_LSB +: CODE_W];
        end
        OFS_PWM: begin
          s_nxt = ratio_apply(s_nxt, i_pwdata);
        end
        default: begin
          s_nxt.code = s_r.code;
        end
      endcase
    end

    // drive outputs follow the registered mode one cycle later
    s_nxt.sink_code = ramp_on ? ramp_level : '0;
    s_nxt.sink_current = ramp_on ? ldc_code_to_current(ramp_level) : '0;
    {s_nxt.sink_en, s_nxt.boost_en, s_nxt.standby_en, s_nxt.feedback} =
      drive_levels(mode, s_r.enable, ramp_on, pwm_on);

    // pushbutton power-down wipes every setting, bus answer state kept
    if (i_pdn_clear) begin
      s_nxt = '0;
      s_nxt.rdata = s_r.rdata;
    end
  end

  // undervoltage reset of the logic supply arrives as i_rstn
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata = s_r.rdata;
  assign o_sink_code = s_r.sink_code;
  assign o_sink_current = s_r.sink_current;
  assign o_sink_en = s_r.sink_en;
  assign o_boost_en = s_r.boost_en;
  assign o_standby_en = s_r.standby_en;
  assign o_feedback_mode = s_r.feedback;
endmodule : ldc_top

// file: hdl/ldc_pkg.sv
// shared constants, types and helpers for the led dimming controller
package ldc_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int ADDR_W = 8;
  localparam int CODE_W = 6;
  localparam int CUR_W = 18;
  localparam int CNT_W = 24;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DAC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PWM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;

  // control word fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SPD_LSB = 1;
  localparam int CTRL_SELA_BIT = 3;
  localparam int CTRL_SELB_BIT = 4;
  localparam int CTRL_CLK_LSB = 5;
  // current code field
  localparam int DAC_CODE_LSB = 0;
  // dimming ratio fields
  localparam int PWM_NUM_LSB = 0;
  localparam int PWM_DEN_LSB = 4;
  // status fields
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_ON_BIT = 8;
  localparam int STAT_PHASE_BIT = 9;
  localparam int STAT_MODE_LSB = 10;
  localparam int STAT_RAMP_BIT = 12;

  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // full ramp times in microseconds, one step per code
  localparam int RAMP_STEPS = 63;
  localparam int RAMP_T0_US = 15000;
  localparam int RAMP_T1_US = 460000;
  localparam int RAMP_T2_US = 930000;
  localparam int RAMP_T3_US = 1850000;
  localparam int RAMP_STEP0_CYC = (RAMP_T0_US * (CLK_HZ / 1_000_000)) / RAMP_STEPS;
  localparam int RAMP_STEP1_CYC = (RAMP_T1_US * (CLK_HZ / 1_000_000)) / RAMP_STEPS;
  localparam int RAMP_STEP2_CYC = (RAMP_T2_US * (CLK_HZ / 1_000_000)) / RAMP_STEPS;
  localparam int RAMP_STEP3_CYC = (RAMP_T3_US * (CLK_HZ / 1_000_000)) / RAMP_STEPS;

  // fastest dimming base clock in hertz; slower ones divide it by 2, 3 and 4
  localparam int PWM_BASE_HZ = 8770;
  localparam int PWM_BASE_CYC = CLK_HZ / PWM_BASE_HZ;

  // eight linear segments, current in units of 0.1 uA at 20 mA full scale
  localparam logic [CUR_W-1:0] SEG_BASE [8] = '{18'h0_00c8, 18'h0_01e1, 18'h0_0488, 18'h0_0adc,
                                                 18'h0_1a18, 18'h0_3ee4, 18'h0_96c8, 18'h1_6ae4};
  localparam logic [13:0] SEG_STEP [8] = '{14'h0023, 14'h0055, 14'h00ca, 14'h01e7,
                                           14'h0499, 14'h0afc, 14'h1a83, 14'h3bc4};

  typedef enum logic [1:0] {
    LDC_MODE_CC,
    LDC_MODE_PWM,
    LDC_MODE_FIXED,
    LDC_MODE_RSVD
  } ldc_mode_e;

  function automatic ldc_mode_e ldc_decode_mode(input logic sel_a, input logic sel_b);
    case ({sel_a, sel_b})
      2'b00: ldc_decode_mode = LDC_MODE_CC;
      2'b01: ldc_decode_mode = LDC_MODE_PWM;
      2'b10: ldc_decode_mode = LDC_MODE_FIXED;
      default: ldc_decode_mode = LDC_MODE_RSVD;
    endcase
  endfunction : ldc_decode_mode

  function automatic logic [CUR_W-1:0] ldc_code_to_current(input logic [CODE_W-1:0] code);
    logic [CUR_W-1:0] part;
    // widen before the product: the top segment needs more than 14 bits
    part = CUR_W'(SEG_STEP[code[5:3]]) * CUR_W'(code[2:0]);
    ldc_code_to_current = SEG_BASE[code[5:3]] + part;
  endfunction : ldc_code_to_current

endpackage : ldc_pkg

// file: hdl/ldc_ramp.sv
// gradual ramp of the applied current code toward its goal
`timescale 1ns/1ps
module ldc_ramp #(
  parameter int STEP0 = ldc_pkg::RAMP_STEP0_CYC,
  parameter int STEP1 = ldc_pkg::RAMP_STEP1_CYC,
  parameter int STEP2 = ldc_pkg::RAMP_STEP2_CYC,
  parameter int STEP3 = ldc_pkg::RAMP_STEP3_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_enable,
  input wire logic [1:0] i_speed,
  input wire logic [ldc_pkg::CODE_W-1:0] i_target,
  output logic [ldc_pkg::CODE_W-1:0] o_level,
  output logic o_on
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CODE_W-1:0] level;
    logic on;
  } ldc_ramp_s;

  ldc_ramp_s s_r;
  ldc_ramp_s s_nxt;
  logic [CNT_W-1:0] step_len;
  logic [CODE_W-1:0] goal;

  always_comb begin
    case (i_speed)
      2'b00: step_len = CNT_W'(STEP0);
      2'b01: step_len = CNT_W'(STEP1);
      2'b10: step_len = CNT_W'(STEP2);
      default: step_len = CNT_W'(STEP3);
    endcase
    goal = i_enable ? i_target : '0;
    s_nxt = s_r;
    if (i_enable) begin
      s_nxt.on = 1'b1;
    end
    if (s_r.level == goal) begin
      s_nxt.cnt = '0; // no stored phase, so every ramp starts a full step
      if (!i_enable) begin
        s_nxt.on = 1'b0; // only off once the way down has finished
      end
    end else if (s_r.cnt >= step_len - 1'b1) begin
      s_nxt.cnt = '0;
      s_nxt.level = (s_r.level < goal) ? s_r.level + 1'b1 : s_r.level - 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    if (i_clear) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.level;
  assign o_on = s_r.on;
endmodule : ldc_ramp

// file: hdl/ldc_pwm.sv
// dimming waveform: base clock divider plus numerator over denominator counter
`timescale 1ns/1ps
module ldc_pwm #(
  parameter int BASE_DIV = ldc_pkg::PWM_BASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic [1:0] i_clk_sel,
  input wire logic [3:0] i_num,
  input wire logic [3:0] i_den,
  output logic o_on,
  output logic o_tick
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [15:0] div;
    logic [1:0] pre;
    logic [3:0] phase;
    logic on;
    logic tick;
  } ldc_pwm_s;

  ldc_pwm_s s_r;
  ldc_pwm_s s_nxt;
  logic base_tick;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    base_tick = (s_r.div >= 16'(BASE_DIV - 1));
    s_nxt.div = base_tick ? '0 : s_r.div + 1'b1;
    if (base_tick) begin
      if (s_r.pre >= i_clk_sel) begin
        s_nxt.pre = '0; // divide by select plus one
        s_nxt.tick = 1'b1;
        // period of den divided ticks; a zero den just holds phase at 0
        s_nxt.phase = (s_r.phase + 1'b1 >= {1'b0, i_den}) ? '0 : s_r.phase + 1'b1;
      end else begin
        s_nxt.pre = s_r.pre + 1'b1;
      end
    end
    // zero num never on, num above den always on
    s_nxt.on = (s_nxt.phase < i_num);
    if (!i_run) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_on = s_r.on;
  assign o_tick = s_r.tick;
endmodule : ldc_pwm

// file: sim/ldc_apb_mst.sv
// register bus master model for the dimming controller bench
`timescale 1ns/1ps
module ldc_apb_mst (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  // enter just after a rising edge; returns just after one
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    // a missing answer returns unknowns so the bench counts it
    q = (i_pready === 1'b1) ? i_prdata : 'x;
    err = (i_pready === 1'b1) ? i_pslverr : 1'bx;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~d;
    // idle cycle between transfers
    @(posedge i_clk);
  endtask : xfer
endmodule : ldc_apb_mst

// file: sim/ldc_props.sv
// bus and drive-output properties for the led dimming controller
`timescale 1ns/1ps
module ldc_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pdn_clear,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ldc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [ldc_pkg::CODE_W-1:0] o_sink_code,
  input wire logic [ldc_pkg::CUR_W-1:0] o_sink_current,
  input wire logic o_sink_en,
  input wire logic o_boost_en,
  input wire logic o_standby_en,
  input wire logic o_feedback_mode
);
  import ldc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ready_zero_wait: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access cycle");
  a_unmapped_err: assert property (i_psel && i_penable && i_paddr > 8'h0c |-> o_pslverr)
    else $error("no error on unmapped address");
  a_reset_clears: assert property (disable iff (1'b0) !i_rstn |=> !o_sink_en && !o_boost_en && o_sink_code == '0)
    else $error("outputs not cleared by reset");
  a_pdn_clears: assert property (i_pdn_clear |-> ##3 !o_sink_en && !o_boost_en && o_sink_code == '0)
    else $error("outputs not cleared by power-down");
  a_ramp_step: assert property (o_sink_code > $past(o_sink_code) |-> o_sink_code == $past(o_sink_code) + 6'd1)
    else $error("code rose by more than one");
  a_current_mono: assert property (o_sink_code > $past(o_sink_code) |-> o_sink_current > $past(o_sink_current))
    else $error("current not monotonic");
  a_full_scale: assert property (o_sink_code == 6'h3f |-> o_sink_current == 18'h3_0d40)
    else $error("full scale current wrong");
  a_boost_pair: assert property (!o_feedback_mode |-> o_sink_en == o_boost_en)
    else $error("sink and boost disagree");
  a_feedback_mode: assert property (o_feedback_mode |-> !o_sink_en && !o_standby_en)
    else $error("sink active in fixed boost");
  c_fixed: cover property (o_feedback_mode);
  c_full: cover property (o_sink_code == 6'h3f);
  c_pwm_off: cover property (o_standby_en && !o_sink_en);
endmodule : ldc_props
bind ldc_top ldc_props u_props (.*);

// file: sim/ldc_top_tb.sv
// self-checking bench for the led dimming controller top
`timescale 1ns/1ps
module ldc_top_tb;
  import ldc_pkg::*;
  localparam int SP [4] = '{2, 3, 4, 5};
  localparam int BD = 4;
  logic i_clk, i_rstn, i_pdn_clear, psel, pen, pwr, rdy, err, e, sk, bst, sb, fb;
  logic [7:0] pa;
  logic [31:0] pwd, prd, q;
  logic [CODE_W-1:0] code;
  logic [CUR_W-1:0] cur;
  int bad_count, tests_run, seed, n, hi, num, den, per;
  int cur_tab [9] = '{200, 481, 1160, 2780, 6680, 16100, 38600, 92900, 200000};

  ldc_top #(.RAMP_STEP0(SP[0]), .RAMP_STEP1(SP[1]), .RAMP_STEP2(SP[2]), .RAMP_STEP3(SP[3]),
    .PWM_BASE_DIV(BD)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_pdn_clear(i_pdn_clear), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .o_sink_code(code), .o_sink_current(cur), .o_sink_en(sk),
    .o_boost_en(bst), .o_standby_en(sb), .o_feedback_mode(fb));
  ldc_apb_mst u_mst (.i_clk(i_clk), .i_pready(rdy), .i_pslverr(err), .i_prdata(prd), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(pa), .o_pwdata(pwd));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // a transfer the slave never answered ends the run as a mismatch
  task automatic bus_guard;
    if (e === 1'bx) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : bus_guard

  task automatic wr(input logic [7:0] a, input int d);
    u_mst.xfer(1'b1, a, 32'(d), q, e);
    bus_guard();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ex_err);
    u_mst.xfer(1'b0, a, 32'h0000_0000, q, e);
    bus_guard();
    chk("rdata", ex, q);
    chk("pslverr", 32'(ex_err), 32'(e));
  endtask : rd

  // bounded wait for the applied code to reach a value
  task automatic wait_code(input int t);
    n = 0;
    while (code !== 6'(t) && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_code

  initial begin
    seed = 32'hc996;
    bad_count = 0;
    tests_run = 0;
    i_rstn = 1'b0;
    i_pdn_clear = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(OFS_STAT, 32'h0000_1fff);
    rd(OFS_STAT, 32'h0000_0000, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 1 | s << CTRL_SPD_LSB);
      wr(OFS_DAC, 10 * (s + 1));
      wait_code(10 * s + 2);
      n = 0;
      while (code === 6'(10 * s + 2) && n < 100) begin
        @(posedge i_clk);
        n++;
      end
      chk("step_len", 32'(SP[s]), 32'(n));
    end
    wr(OFS_DAC, 63);
    for (int k = 8; k >= 0; k--) begin
      if (k < 8) wr(OFS_DAC, 8 * k);
      wait_code(k == 8 ? 63 : 8 * k);
      @(posedge i_clk);
      chk("current", 32'(cur_tab[k]), 32'(cur));
      chk("cc_sink", 32'h0000_0001, 32'(sk));
    end
    wr(OFS_DAC, 20);
    wait_code(20);
    wr(OFS_CTRL, 3 << CTRL_SPD_LSB);
    chk("ramp_down_on", 32'h0000_0001, 32'(sk));
    wait_code(0);
    repeat (4) @(posedge i_clk);
    chk("ramp_down_off", 32'h0000_0000, 32'(sk));
    wr(OFS_DAC, 5);
    for (int s = 0; s < 4; s++) begin
      den = 1 + {$random(seed)} % 15;
      num = (s == 0) ? 0 : (s == 3) ? 15 : {$random(seed)} % 16;
      wr(OFS_PWM, num | den << PWM_DEN_LSB);
      wr(OFS_CTRL, 1 | 1 << CTRL_SELB_BIT | s << CTRL_CLK_LSB);
      per = den * (s + 1) * BD;
      repeat (per + 300) @(posedge i_clk);
      hi = 0;
      repeat (per) begin
        @(posedge i_clk);
        hi += int'(sk === 1'b1);
      end
      chk("duty", 32'((num > den ? den : num) * (s + 1) * BD), 32'(hi));
      chk("standby", 32'h0000_0001, 32'(sb));
      chk("boost", 32'(sk), 32'(bst));
    end
    wr(OFS_CTRL, 1 | 1 << CTRL_SELA_BIT);
    repeat (4) @(posedge i_clk);
    chk("fixed", 32'h0000_0005, 32'({sk, bst, sb, fb}));
    wr(OFS_CTRL, 1 | 3 << CTRL_SELA_BIT);
    repeat (4) @(posedge i_clk);
    chk("reserved", 32'h0000_0000, 32'({sk, bst, sb, fb}));
    wr(OFS_CTRL, 1);
    i_pdn_clear <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_pdn_clear <= 1'b0;
    @(posedge i_clk);
    rd(OFS_CTRL, 32'h0000_0000, 1'b0);
    wr(OFS_DAC, 7);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(OFS_DAC, 32'h0000_0000, 1'b0);
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (50000) @(posedge i_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : ldc_top_tb
